// >>> shared/agu_pkg.sv
// package of constants and types for the address generation unit
package agu_pkg;
   // register indices on the plain register port
   localparam logic [2:0] OFS_MODCTL = 3'h0;
   localparam logic [2:0] OFS_XSTART = 3'h1;
   localparam logic [2:0] OFS_XEND   = 3'h2;
   localparam logic [2:0] OFS_YSTART = 3'h3;
   localparam logic [2:0] OFS_YEND   = 3'h4;
   localparam logic [2:0] OFS_STATUS = 3'h5;
   // control field positions
   localparam int XSEL_LSB  = 0;
   localparam int YSEL_LSB  = 4;
   localparam int YEN_BIT   = 14;
   localparam int XEN_BIT   = 15;
   localparam logic [3:0] SEL_OFF = 4'hf;
   // reset values
   localparam logic [15:0] RST_MODCTL = 16'h00ff;
   localparam logic [15:0] RST_BOUND  = 16'h0000;
   // direct field and literal widths, and the default working register number
   localparam int FILE_ADDR_W = 13;
   localparam int SHORT_LIT_W = 5;
   localparam int BRANCH_W    = 16;
   localparam int INTERRUPT_DISABLE_COUNT_INSTR_W      = 14;
   localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REGISTER = 4'h0;
   // dual-source prefetch registers
   localparam logic [3:0] DS_X_LO = 4'h8;
   localparam logic [3:0] DS_X_IX = 4'h9;
   localparam logic [3:0] DS_Y_LO = 4'ha;
   localparam logic [3:0] DS_Y_IX = 4'hb;

   typedef enum logic [3:0] {
      AM_FILE, AM_DIRECT, AM_IND, AM_POST, AM_PRE, AM_REGIDX, AM_LITOFS, AM_DUAL
   } agu_mode_t;
endpackage

// >>> rtl/agu_core.sv
// effective address generation with circular buffer correction
`timescale 1ns/1ns
module agu_core
   import agu_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   // source and destination address request
   input  wire logic        req_valid,
   input  wire agu_mode_t   src_mode,
   input  wire agu_mode_t   dst_mode,
   input  wire logic        dst_valid,
   input  wire logic        y_space,
   input  wire logic [3:0]  src_ptr,
   input  wire logic [15:0] src_ptr_val,
   input  wire logic [3:0]  dst_ptr,
   input  wire logic [15:0] dst_ptr_val,
   input  wire logic [3:0]  offset_reg,
   input  wire logic [15:0] offset_val,
   input  wire logic [15:0] step,
   input  wire logic [15:0] literal,
   input  wire logic [12:0] file_addr,
   input  wire logic        file_to_default_working_register,
   input  wire logic [1:0]  dual_step,
   input  wire logic [SHORT_LIT_W-1:0] short_lit,
   input  wire logic        short_lit_sel,
   input  wire logic [BRANCH_W-1:0]    branch_disp,
   input  wire logic [INTERRUPT_DISABLE_COUNT_INSTR_W-1:0]      interrupt_disable_count_instr_count,
   // answers, one cycle after the request
   output logic             ans_valid,
   output logic [15:0]      src_ea,
   output logic [15:0]      dst_ea,
   output logic             src_wb,
   output logic [3:0]       src_wb_reg,
   output logic [15:0]      src_wb_val,
   output logic             dst_wb,
   output logic [3:0]       dst_wb_reg,
   output logic [15:0]      dst_wb_val,
   output logic [3:0]       result_default_working_register,
   output logic             result_to_default_working_register,
   output logic [15:0]      operand2,
   output logic [15:0]      branch_ofs,
   output logic [15:0]      interrupt_disable_count_instr_ofs,
   output logic             mode_error
);
   // =====================================================
   // state
   typedef struct packed {
      logic [15:0] modctl;
      logic [15:0] xs, xe, ys, ye;
      logic [15:0] rdata;
      logic        av;
      logic [15:0] sea, dea;
      logic        swb, dwb;
      logic [3:0]  swr, dwr;
      logic [15:0] swv, dwv;
      logic [3:0]  rwr;
      logic        rtw;
      logic [15:0] op2, bro, dso;
      logic        err;
      logic        wrapped;
   } agu_state_t;

   agu_state_t s_q, s_d;

   // =====================================================
   // one address calculation with circular correction
   typedef struct packed {
      logic [15:0] ea;
      logic        wb;
      logic [15:0] wv;
      logic        err;
      logic        wrap;
   } agu_res_t;

   function automatic logic is_pow2(input logic [16:0] n);
      is_pow2 = (n != 17'h0) && ((n & (n - 17'h1)) == 17'h0);
   endfunction

   function automatic agu_res_t calc(
      input agu_mode_t   m,
      input logic [3:0]  p,
      input logic [15:0] pv,
      input logic [15:0] ofs,
      input logic [15:0] stp,
      input logic [15:0] lit,
      input logic [12:0] fa,
      input logic [1:0]  dstep,
      input logic        ysp,
      input logic [15:0] mc,
      input logic [15:0] xs,
      input logic [15:0] xe,
      input logic [15:0] ys,
      input logic [15:0] ye);
      agu_res_t    r;
      logic [15:0] raw, base, lo, hi, len;
      logic        modon, inc, dec, bidir;
      r    = '0;
      raw  = pv;
      base = pv;
      case (m)
         AM_FILE:   raw = {3'h0, fa};
         AM_IND:    raw = pv;
         AM_POST:   begin
            raw  = pv;
            base = pv + stp;
            r.wb = 1'b1;
         end
         AM_PRE:    begin
            raw  = pv + stp;
            base = raw;
            r.wb = 1'b1;
         end
         AM_REGIDX: raw = pv + ofs;
         AM_LITOFS: raw = pv + lit;
         AM_DUAL:   begin
            if (ysp ? (p != DS_Y_LO && p != DS_Y_IX) : (p != DS_X_LO && p != DS_X_IX))
               r.err = 1'b1;
            raw = pv;
            if (dstep == 2'h3) begin
               if (ysp ? (p != DS_Y_IX) : (p != DS_X_IX))
                  r.err = 1'b1;
               raw = pv + ofs;
            end else if (dstep != 2'h0) begin
               base = pv + {13'h0, dstep, 1'b0};
               r.wb = 1'b1;
            end
         end
         default:   raw = pv;
      endcase
      modon = ysp ? (mc[YSEL_LSB +: 4] != SEL_OFF && mc[YEN_BIT] && mc[YSEL_LSB +: 4] == p)
                  : (mc[XSEL_LSB +: 4] != SEL_OFF && mc[XEN_BIT] && mc[XSEL_LSB +: 4] == p);
      lo  = ysp ? ys : xs;
      hi  = ysp ? ye : xe;
      len = hi - lo + 16'h1;
      bidir = is_pow2({1'b0, len});
      inc = bidir || stp[15] == 1'b0;
      dec = bidir || stp[15] == 1'b1;
      r.ea = raw;
      r.wv = base;
      if (modon && m != AM_FILE && m != AM_DIRECT) begin
         if (inc && raw > hi)
            r.ea = raw - len;
         else if (dec && raw < lo)
            r.ea = raw + len;
         if (inc && base > hi)
            r.wv = base - len;
         else if (dec && base < lo)
            r.wv = base + len;
         r.wrap = (r.ea != raw) || (r.wv != base);
         if (m == AM_PRE)
            r.wv = r.ea;
      end
      if (ysp && modon)
         r.ea[0] = 1'b0;
      if (ysp && modon)
         r.wv[0] = 1'b0;
      calc = r;
   endfunction

   agu_res_t sr, dr;

   // =====================================================
   // next state
   always_comb begin
      s_d   = s_q;
      sr    = calc(src_mode, src_ptr, src_ptr_val, offset_val, step, literal, file_addr,
                   dual_step, y_space, s_q.modctl, s_q.xs, s_q.xe, s_q.ys, s_q.ye);
      dr    = calc(dst_mode, dst_ptr, dst_ptr_val, offset_val, step, literal, file_addr,
                   2'h0, 1'b0, s_q.modctl, s_q.xs, s_q.xe, s_q.ys, s_q.ye);
      s_d.av = req_valid;
      if (reg_wr) begin
         if (reg_addr == OFS_MODCTL)
            s_d.modctl = reg_wdata;
         else if (reg_addr == OFS_XSTART)
            s_d.xs = reg_wdata;
         else if (reg_addr == OFS_XEND)
            s_d.xe = reg_wdata;
         else if (reg_addr == OFS_YSTART)
            s_d.ys = reg_wdata;
         else if (reg_addr == OFS_YEND)
            s_d.ye = reg_wdata;
      end
      s_d.rdata = 16'h0000;
      if (reg_rd) begin
         if (reg_addr == OFS_MODCTL)
            s_d.rdata = s_q.modctl;
         else if (reg_addr == OFS_XSTART)
            s_d.rdata = s_q.xs;
         else if (reg_addr == OFS_XEND)
            s_d.rdata = s_q.xe;
         else if (reg_addr == OFS_YSTART)
            s_d.rdata = s_q.ys;
         else if (reg_addr == OFS_YEND)
            s_d.rdata = s_q.ye;
         else if (reg_addr == OFS_STATUS)
            s_d.rdata = {14'h0, s_q.wrapped, s_q.err};
      end
      if (req_valid) begin
         s_d.sea = sr.ea;
         s_d.swb = sr.wb;
         s_d.swr = src_ptr;
         s_d.swv = sr.wv;
         s_d.dea = dr.ea;
         s_d.dwb = dst_valid && dr.wb;
         s_d.dwr = dst_ptr;
         s_d.dwv = dr.wv;
         s_d.err = sr.err;
         s_d.wrapped = sr.wrap || (dst_valid && dr.wrap);
         s_d.rwr = file_to_default_working_register ? DEFAULT_DEFAULT_WORKING_REGISTER : offset_reg;
         s_d.rtw = file_to_default_working_register;
         s_d.op2 = short_lit_sel ? {11'h0, short_lit} : offset_val;
         s_d.bro = branch_disp;
         s_d.dso = {2'h0, interrupt_disable_count_instr_count};
      end else begin
         s_d.swb = 1'b0;
         s_d.dwb = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q        <= '0;
         s_q.modctl <= RST_MODCTL;
         s_q.xs     <= RST_BOUND;
         s_q.xe     <= RST_BOUND;
         s_q.ys     <= RST_BOUND;
         s_q.ye     <= RST_BOUND;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata      = s_q.rdata;
   assign ans_valid      = s_q.av;
   assign src_ea         = s_q.sea;
   assign dst_ea         = s_q.dea;
   assign src_wb         = s_q.swb;
   assign src_wb_reg     = s_q.swr;
   assign src_wb_val     = s_q.swv;
   assign dst_wb         = s_q.dwb;
   assign dst_wb_reg     = s_q.dwr;
   assign dst_wb_val     = s_q.dwv;
   assign result_default_working_register    = s_q.rwr;
   assign result_to_default_working_register = s_q.rtw;
   assign operand2       = s_q.op2;
   assign branch_ofs     = s_q.bro;
   assign interrupt_disable_count_instr_ofs       = s_q.dso;
   assign mode_error     = s_q.err;

   // =====================================================
   // checks
   AST_FILE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_FILE |=> src_ea == {3'h0, $past(file_addr)})
      else $error("file address wrong");
   AST_IND: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_IND && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_ea == $past(src_ptr_val) && !src_wb)
      else $error("indirect changed pointer");
   AST_POST: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_POST && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_wb && src_wb_val == $past(src_ptr_val) + $past(step))
      else $error("post modify wrong");
   AST_PRE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_PRE |=> src_ea == src_wb_val && src_wb)
      else $error("pre modify mismatch");
   AST_IDX: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_REGIDX |=> !src_wb)
      else $error("indexed wrote back");
   AST_LIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_LITOFS |=> !src_wb)
      else $error("literal offset wrote back");
   AST_DUAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_DUAL && !y_space && src_ptr == DS_Y_LO |=> mode_error)
      else $error("Y register on X unit not flagged");
   AST_YLSB: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && y_space && s_q.modctl[YEN_BIT] && s_q.modctl[YSEL_LSB +: 4] != SEL_OFF
      && s_q.modctl[YSEL_LSB +: 4] == src_ptr && src_mode != AM_FILE |=> src_ea[0] == 1'b0)
      else $error("Y circular address odd");
   AST_XOFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && !y_space && s_q.modctl[XSEL_LSB +: 4] == SEL_OFF && src_mode == AM_IND
      |=> src_ea == $past(src_ptr_val))
      else $error("X modulo active while off");
   AST_RDLAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFS_XEND && !reg_wr |=> reg_rdata == $past(s_q.xe))
      else $error("read data wrong");

   // =====================================================
   // address arithmetic checks with circular buffers off
   AST_POST_EA: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_POST && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_ea == $past(src_ptr_val)) else $error("post modify address wrong");
   AST_PRE_EA: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_PRE && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_ea == $past(src_ptr_val) + $past(step)) else $error("pre modify address wrong");
   AST_IDX_EA: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_REGIDX && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_ea == $past(src_ptr_val) + $past(offset_val)) else $error("indexed address wrong");
   AST_LIT_EA: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_LITOFS && !s_q.modctl[XEN_BIT] && !s_q.modctl[YEN_BIT]
      |=> src_ea == $past(src_ptr_val) + $past(literal)) else $error("literal address wrong");
   AST_DST_IDX: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && dst_valid && dst_mode == AM_REGIDX && !s_q.modctl[XEN_BIT]
      |=> dst_ea == $past(dst_ptr_val) + $past(offset_val)) else $error("dest address wrong");

   // =====================================================
   // dual-source pointer checks
   AST_DUAL_XREG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_DUAL && y_space && src_ptr == DS_X_IX |=> mode_error)
      else $error("X register on Y unit not flagged");
   AST_DUAL_OK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_DUAL && !y_space && (src_ptr == DS_X_LO || src_ptr == DS_X_IX)
      && dual_step != 2'h3 |=> !mode_error) else $error("legal dual pointer flagged");
   AST_DUAL_IX: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_DUAL && !y_space && src_ptr == DS_X_LO && dual_step == 2'h3
      |=> mode_error) else $error("indexed on wrong register not flagged");
   AST_DUAL_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_DUAL && dual_step == 2'h2 && !s_q.modctl[XEN_BIT]
      && !s_q.modctl[YEN_BIT] |=> src_wb && src_wb_val == $past(src_ptr_val) + 16'h0004)
      else $error("dual post modify wrong");

   // =====================================================
   // operand and literal checks
   AST_DEFAULT_WORKING_REGISTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && file_to_default_working_register |=> result_to_default_working_register && result_default_working_register == DEFAULT_DEFAULT_WORKING_REGISTER)
      else $error("default working register not used");
   AST_OP2LIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && short_lit_sel |=> operand2 == {11'h0, $past(short_lit)})
      else $error("short literal operand wrong");
   AST_OP2REG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && !short_lit_sel |=> operand2 == $past(offset_val))
      else $error("register operand wrong");
   AST_BRANCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid |=> branch_ofs == $past(branch_disp))
      else $error("branch displacement wrong");
   AST_INTERRUPT_DISABLE_COUNT_INSTR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid |=> interrupt_disable_count_instr_ofs == {2'h0, $past(interrupt_disable_count_instr_count)})
      else $error("disable count wrong");
   AST_FILE_WB: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req_valid && src_mode == AM_FILE |=> !src_wb)
      else $error("file access wrote a pointer");

   // =====================================================
   // strobe and idle checks
   AST_RDIDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   AST_IDLE_WB: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !req_valid |=> !ans_valid && !src_wb && !dst_wb)
      else $error("write back without request");
endmodule

// >>> testbench/agu_core_tb_top.sv
// self-checking testbench for the address generation unit
`timescale 1ns/1ns
module agu_core_tb_top;
   import agu_pkg::*;
   typedef struct packed {
      logic [2:0]  k;
      logic [15:0] v;
      logic        wb;
      logic [15:0] wv;
      logic        err;
      logic [15:0] o2;
      logic [15:0] br;
      logic [15:0] di;
   } agu_exp_t;
   logic ref_clk, rst_n, reg_wr, reg_rd, req_valid, dst_valid, y_space;
   logic file_to_default_working_register, short_lit_sel, ans_valid, src_wb, dst_wb, result_to_default_working_register, mode_error;
   logic [2:0] reg_addr;
   logic [3:0] src_ptr, dst_ptr, offset_reg, src_wb_reg, dst_wb_reg, result_default_working_register;
   logic [15:0] reg_wdata, reg_rdata, src_ptr_val, dst_ptr_val, offset_val, step, literal;
   logic [15:0] src_ea, dst_ea, src_wb_val, dst_wb_val, operand2, branch_ofs, interrupt_disable_count_instr_ofs;
   logic [12:0] file_addr;
   logic [1:0]  dual_step;
   logic [SHORT_LIT_W-1:0] short_lit;
   logic [BRANCH_W-1:0]    branch_disp;
   logic [INTERRUPT_DISABLE_COUNT_INSTR_W-1:0]      interrupt_disable_count_instr_count;
   agu_mode_t   src_mode, dst_mode;
   agu_exp_t    exq[$];
   agu_exp_t    got;
   logic [15:0] rq[$];
   logic        rd_seen;
   logic [31:0] rnd_s, r;
   logic [15:0] ov, lv;
   int          n_mismatch, checked, i;

   agu_core u_agu_core (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .req_valid(req_valid), .src_mode(src_mode), .dst_mode(dst_mode), .dst_valid(dst_valid),
      .y_space(y_space), .src_ptr(src_ptr), .src_ptr_val(src_ptr_val), .dst_ptr(dst_ptr),
      .dst_ptr_val(dst_ptr_val), .offset_reg(offset_reg), .offset_val(offset_val),
      .step(step), .literal(literal), .file_addr(file_addr), .file_to_default_working_register(file_to_default_working_register),
      .dual_step(dual_step), .short_lit(short_lit), .short_lit_sel(short_lit_sel),
      .branch_disp(branch_disp), .interrupt_disable_count_instr_count(interrupt_disable_count_instr_count), .ans_valid(ans_valid),
      .src_ea(src_ea), .dst_ea(dst_ea), .src_wb(src_wb), .src_wb_reg(src_wb_reg),
      .src_wb_val(src_wb_val), .dst_wb(dst_wb), .dst_wb_reg(dst_wb_reg),
      .dst_wb_val(dst_wb_val), .result_default_working_register(result_default_working_register), .result_to_default_working_register(result_to_default_working_register),
      .operand2(operand2), .branch_ofs(branch_ofs), .interrupt_disable_count_instr_ofs(interrupt_disable_count_instr_ofs),
      .mode_error(mode_error));

   // ==========================================
   // helpers
   function automatic logic [31:0] xrand();
      rnd_s = rnd_s ^ (rnd_s << 13);
      rnd_s = rnd_s ^ (rnd_s >> 17);
      rnd_s = rnd_s ^ (rnd_s << 5);
      return rnd_s;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(exp);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic req(input agu_exp_t e);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      exq.push_back(e);
      @(posedge ref_clk);
      req_valid <= 1'b0;
   endtask
   task automatic src_req(input agu_mode_t m, input logic [3:0] p, input logic [15:0] pv,
                          input logic [15:0] stp, input logic [15:0] ev, input logic ewb,
                          input logic [15:0] ewv, input logic eerr);
      agu_exp_t e;
      e = '0;
      e.v = ev;
      e.wb = ewb;
      e.wv = ewv;
      e.err = eerr;
      src_mode <= m;
      src_ptr <= p;
      src_ptr_val <= pv;
      step <= stp;
      req(e);
   endtask

   // ==========================================
   // result watcher
   always @(posedge ref_clk) begin
      if (rd_seen) begin
         if (rq.size() == 0) n_mismatch++;
         else check(reg_rdata, rq.pop_front());
      end
      rd_seen <= (reg_rd === 1'b1);
      if (ans_valid === 1'b1) begin
         if (exq.size() == 0) begin
            n_mismatch++;
         end else begin
            got = exq.pop_front();
            if (got.k == 3'h1) begin
               check(dst_ea, got.v);
            end else if (got.k == 3'h5) begin
               check(src_ea, got.v);
               check({15'h0, result_to_default_working_register}, {15'h0, got.wb});
               check({12'h0, result_default_working_register}, {12'h0, DEFAULT_DEFAULT_WORKING_REGISTER});
               check(operand2, got.o2);
               check(branch_ofs, got.br);
               check(interrupt_disable_count_instr_ofs, got.di);
            end else begin
               check({15'h0, mode_error}, {15'h0, got.err});
               if (!got.err) begin
                  check(src_ea, got.v);
                  check({15'h0, src_wb}, {15'h0, got.wb});
                  if (got.wb) check(src_wb_val, got.wv);
               end
            end
         end
      end
   end

   // ==========================================
   // stimulus
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      {rst_n, reg_wr, reg_rd, req_valid, dst_valid, y_space, file_to_default_working_register, short_lit_sel} = '0;
      {reg_addr, src_ptr, dst_ptr, offset_reg, reg_wdata, src_ptr_val, dst_ptr_val} = '0;
      {offset_val, step, literal, file_addr, dual_step, short_lit} = '0;
      {branch_disp, interrupt_disable_count_instr_count, rd_seen, n_mismatch, checked} = '0;
      src_mode = AM_IND;
      dst_mode = AM_IND;
      rnd_s = 32'h544dd4cc;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(OFS_MODCTL, RST_MODCTL);
      for (i = 1; i < 5; i++) rd(i[2:0], RST_BOUND);
      wr(3'h6, 16'hffff);
      rd(3'h6, 16'h0000);
      for (i = 1; i < 5; i++) wr(i[2:0], 16'h8a5c ^ i[15:0]);
      for (i = 1; i < 5; i++) rd(i[2:0], 16'h8a5c ^ i[15:0]);
      for (i = 0; i < 30; i++) begin
         r = xrand();
         ov = r[31:16];
         lv = r[15:0];
         offset_val <= ov;
         literal <= lv;
         r = xrand();
         case (r[2:0] % 5)
            0: src_req(AM_IND, 4'h1, r[31:16], r[15:0], r[31:16], 1'b0, 16'h0, 1'b0);
            1: src_req(AM_POST, 4'h1, r[31:16], r[15:0], r[31:16], 1'b1,
                       r[31:16] + r[15:0], 1'b0);
            2: src_req(AM_PRE, 4'h1, r[31:16], r[15:0], r[31:16] + r[15:0], 1'b1,
                       r[31:16] + r[15:0], 1'b0);
            3: src_req(AM_REGIDX, 4'h1, r[31:16], r[15:0], r[31:16] + ov, 1'b0,
                       16'h0, 1'b0);
            default: src_req(AM_LITOFS, 4'h1, r[31:16], r[15:0], r[31:16] + lv, 1'b0,
                             16'h0, 1'b0);
         endcase
      end
      for (i = 0; i < 6; i++) begin
         r = xrand();
         src_mode <= AM_FILE;
         file_addr <= r[12:0];
         file_to_default_working_register <= r[13];
         short_lit_sel <= 1'b1;
         short_lit <= r[18:14];
         branch_disp <= r[31:16];
         interrupt_disable_count_instr_count <= r[29:16];
         got = '0;
         got.k = 3'h5;
         got.v = {3'h0, r[12:0]};
         got.wb = r[13];
         got.o2 = {11'h0, r[18:14]};
         got.br = r[31:16];
         got.di = {2'h0, r[29:16]};
         req(got);
      end
      got = '0;
      got.k = 3'h1;
      got.v = 16'h0422;
      dst_valid <= 1'b1;
      dst_mode <= AM_REGIDX;
      dst_ptr_val <= 16'h0400;
      offset_val <= 16'h0022;
      src_mode <= AM_IND;
      req(got);
      dst_valid <= 1'b0;
      for (i = 4; i < 12; i++) begin
         y_space <= (i > 9);
         dual_step <= 2'h1;
         src_req(AM_DUAL, i[3:0], 16'h0800, 16'h0, 16'h0800, 1'b1, 16'h0802, i < 8);
      end
      y_space <= 1'b0;
      dual_step <= 2'h3;
      src_req(AM_DUAL, DS_X_IX, 16'h0800, 16'h0, 16'h0822, 1'b0, 16'h0, 1'b0);
      src_req(AM_DUAL, DS_X_LO, 16'h0800, 16'h0, 16'h0, 1'b0, 16'h0, 1'b1);
      rd(OFS_STATUS, 16'h0001);
      y_space <= 1'b1;
      dual_step <= 2'h2;
      src_req(AM_DUAL, DS_Y_IX, 16'h0a00, 16'h0, 16'h0a00, 1'b1, 16'h0a04, 1'b0);
      dual_step <= 2'h0;
      src_req(AM_DUAL, DS_Y_LO, 16'h0a00, 16'h0, 16'h0a00, 1'b0, 16'h0, 1'b0);
      y_space <= 1'b0;
      wr(OFS_XSTART, 16'h1000);
      wr(OFS_XEND, 16'h100f);
      wr(OFS_MODCTL, 16'h80f2);
      rd(OFS_MODCTL, 16'h80f2);
      src_req(AM_POST, 4'h2, 16'h100e, 16'h0004, 16'h100e, 1'b1, 16'h1002, 1'b0);
      rd(OFS_STATUS, 16'h0002);
      src_req(AM_POST, 4'h2, 16'h100e, 16'h0002, 16'h100e, 1'b1, 16'h1000, 1'b0);
      src_req(AM_PRE, 4'h2, 16'h100e, 16'h0004, 16'h1002, 1'b1, 16'h1002, 1'b0);
      offset_val <= 16'h0004;
      src_req(AM_REGIDX, 4'h2, 16'h100e, 16'h0, 16'h1002, 1'b0, 16'h0, 1'b0);
      src_req(AM_POST, 4'h2, 16'h1000, 16'hfffe, 16'h1000, 1'b1, 16'h100e, 1'b0);
      src_req(AM_POST, 4'h3, 16'h100e, 16'h0004, 16'h100e, 1'b1, 16'h1012, 1'b0);
      wr(OFS_MODCTL, 16'h00f2);
      src_req(AM_POST, 4'h2, 16'h100e, 16'h0004, 16'h100e, 1'b1, 16'h1012, 1'b0);
      wr(OFS_MODCTL, 16'h80ff);
      src_req(AM_POST, 4'h2, 16'h100e, 16'h0004, 16'h100e, 1'b1, 16'h1012, 1'b0);
      wr(OFS_YSTART, 16'h3000);
      wr(OFS_YEND, 16'h301f);
      wr(OFS_MODCTL, 16'h405f);
      y_space <= 1'b1;
      src_req(AM_POST, 4'h5, 16'h301e, 16'h0004, 16'h301e, 1'b1, 16'h3002, 1'b0);
      src_req(AM_IND, 4'h5, 16'h3005, 16'h0, 16'h3004, 1'b0, 16'h0, 1'b0);
      wr(OFS_MODCTL, 16'h005f);
      src_req(AM_POST, 4'h5, 16'h301e, 16'h0004, 16'h301e, 1'b1, 16'h3022, 1'b0);
      for (i = 0; i < 20 && (exq.size() != 0 || rq.size() != 0); i++) @(posedge ref_clk);
      if (exq.size() != 0 || rq.size() != 0) n_mismatch++;
      end_sim();
   end
endmodule
